// File: rtl/jvc_defs.svh
// constants for the vendor command extension of the test access port
`ifndef JVC_DEFS_SVH
`define JVC_DEFS_SVH
`define JVC_IR_LEN 4
`define JVC_IR_RESET 4'hf
`define JVC_IR_CAPTURE 4'h1
`define JVC_INS_BYPASS 4'hf
`define JVC_INS_VENDOR_SCAN 4'h7
`define JVC_INS_CMD_SELECT 4'h8
`define JVC_CMD_LEN 8
`define JVC_CMD_RESET 8'h00
`define JVC_CMD_MASTER_CLEAR 8'h01
`define JVC_CMD_PIN_REMAP 8'h02
`define JVC_SCAN_LEN 16
`define JVC_SCAN_RESET 16'h0000
`define JVC_MASTER_CLEAR_RESET_TIME_NS 128
`define JVC_CLK_PERIOD_NS 8
`define JVC_MASTER_CLEAR_RESET_CYCLES (`JVC_MASTER_CLEAR_RESET_TIME_NS / `JVC_CLK_PERIOD_NS)
`define JVC_MASTER_CLEAR_RESET_CNT_W 5
`endif

// File: rtl/jvc_pkg.sv
// types for the vendor command extension of the test access port
`default_nettype none
package jvc_pkg;
    // test access port controller states
    typedef enum logic [3:0] {
        JVC_RESET, JVC_IDLE, JVC_SEL_DR, JVC_CAP_DR, JVC_SHIFT_DR,
        JVC_EXIT1_DR, JVC_PAUSE_DR, JVC_EXIT2_DR, JVC_UPD_DR,
        JVC_SEL_IR, JVC_CAP_IR, JVC_SHIFT_IR, JVC_EXIT1_IR,
        JVC_PAUSE_IR, JVC_EXIT2_IR, JVC_UPD_IR
    } jvc_tap_t;
endpackage : jvc_pkg
`default_nettype wire

// File: rtl/jvc_top.sv
// test access port with vendor scan and command registers
`timescale 1ns/1ps
`include "jvc_defs.svh"
`default_nettype none

module jvc_top (
    // system clock domain
    input wire logic clk,
    input wire logic nrst,
    input wire logic en,
    // test access port pins, link clock domain
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // programming engine side
    output logic prog_clock_pin,
    output logic prog_data_pin,
    input wire logic prog_data_out,
    input wire logic prog_data_out_oe,
    // device side, system clock domain except vendor_scan_value, which comes from the link domain
    output logic master_clear_reset,
    output logic prog_remap_active,
    output logic enhanced_prog_allowed,
    output logic [`JVC_SCAN_LEN-1:0] vendor_scan_value
);
    // link domain state
    jvc_pkg::jvc_tap_t tap, next_tap;            // controller state
    logic [`JVC_IR_LEN-1:0] ir_sh, next_ir_sh;   // instruction shifter
    logic [`JVC_IR_LEN-1:0] ir, next_ir;         // active instruction
    logic [`JVC_CMD_LEN-1:0] cmd_sh, next_cmd_sh; // command shifter
    logic [`JVC_SCAN_LEN-1:0] scan_sh, next_scan_sh; // vendor scan shifter
    logic [`JVC_SCAN_LEN-1:0] scan, next_scan;   // vendor scan update value
    logic byp, next_byp;                         // bypass stage
    logic master_clear_reset_tgl, next_master_clear_reset_tgl;               // master clear event toggle
    logic remap, next_remap;                     // pin remap level
    logic tdo_q, next_tdo_q;                     // falling edge output stage
    logic tdo_en_q, next_tdo_en_q;               // output enable stage
    // system domain state
    logic [2:0] master_clear_reset_sync, next_master_clear_reset_sync;       // toggle synchroniser
    logic [1:0] remap_sync, next_remap_sync;     // level synchroniser
    logic [`JVC_MASTER_CLEAR_RESET_CNT_W-1:0] master_clear_reset_cnt, next_master_clear_reset_cnt; // reset length
    logic master_clear_reset_out, next_master_clear_reset_out;               // registered reset output

    // decode of the selected data register, used by shift, update and output
    function automatic logic [1:0] dr_sel(input logic [`JVC_IR_LEN-1:0] i);
        if (i == `JVC_INS_VENDOR_SCAN) begin
            dr_sel = 2'h1;
        end else if (i == `JVC_INS_CMD_SELECT) begin
            dr_sel = 2'h2;
        end else begin
            dr_sel = 2'h0;                       // bypass for all else
        end
    endfunction : dr_sel

    // controller next state from tms
    always_comb begin
        next_tap = tap;
        case (tap)
            jvc_pkg::JVC_RESET:
                next_tap = tms ? jvc_pkg::JVC_RESET : jvc_pkg::JVC_IDLE;
            jvc_pkg::JVC_IDLE:
                next_tap = tms ? jvc_pkg::JVC_SEL_DR : jvc_pkg::JVC_IDLE;
            jvc_pkg::JVC_SEL_DR:
                next_tap = tms ? jvc_pkg::JVC_SEL_IR : jvc_pkg::JVC_CAP_DR;
            jvc_pkg::JVC_CAP_DR:
                next_tap = tms ? jvc_pkg::JVC_EXIT1_DR : jvc_pkg::JVC_SHIFT_DR;
            jvc_pkg::JVC_SHIFT_DR:
                next_tap = tms ? jvc_pkg::JVC_EXIT1_DR : jvc_pkg::JVC_SHIFT_DR;
            jvc_pkg::JVC_EXIT1_DR:
                next_tap = tms ? jvc_pkg::JVC_UPD_DR : jvc_pkg::JVC_PAUSE_DR;
            jvc_pkg::JVC_PAUSE_DR:
                next_tap = tms ? jvc_pkg::JVC_EXIT2_DR : jvc_pkg::JVC_PAUSE_DR;
            jvc_pkg::JVC_EXIT2_DR:
                next_tap = tms ? jvc_pkg::JVC_UPD_DR : jvc_pkg::JVC_SHIFT_DR;
            jvc_pkg::JVC_UPD_DR:
                next_tap = tms ? jvc_pkg::JVC_SEL_DR : jvc_pkg::JVC_IDLE;
            jvc_pkg::JVC_SEL_IR:
                next_tap = tms ? jvc_pkg::JVC_RESET : jvc_pkg::JVC_CAP_IR;
            jvc_pkg::JVC_CAP_IR:
                next_tap = tms ? jvc_pkg::JVC_EXIT1_IR : jvc_pkg::JVC_SHIFT_IR;
            jvc_pkg::JVC_SHIFT_IR:
                next_tap = tms ? jvc_pkg::JVC_EXIT1_IR : jvc_pkg::JVC_SHIFT_IR;
            jvc_pkg::JVC_EXIT1_IR:
                next_tap = tms ? jvc_pkg::JVC_UPD_IR : jvc_pkg::JVC_PAUSE_IR;
            jvc_pkg::JVC_PAUSE_IR:
                next_tap = tms ? jvc_pkg::JVC_EXIT2_IR : jvc_pkg::JVC_PAUSE_IR;
            jvc_pkg::JVC_EXIT2_IR:
                next_tap = tms ? jvc_pkg::JVC_UPD_IR : jvc_pkg::JVC_SHIFT_IR;
            jvc_pkg::JVC_UPD_IR:
                next_tap = tms ? jvc_pkg::JVC_SEL_DR : jvc_pkg::JVC_IDLE;
            default:
                next_tap = jvc_pkg::JVC_RESET;
        endcase
        // once remapped, tck clocks programming and the controller rests
        if (remap) begin
            next_tap = tap;
        end
    end

    // registers of the port: capture, shift and update
    always_comb begin
        next_ir_sh = ir_sh;
        next_ir = ir;
        next_cmd_sh = cmd_sh;
        next_scan_sh = scan_sh;
        next_scan = scan;
        next_byp = byp;
        next_master_clear_reset_tgl = master_clear_reset_tgl;
        next_remap = remap;
        case (tap)
            // test logic reset restores the bypass instruction
            jvc_pkg::JVC_RESET: begin
                next_ir = `JVC_IR_RESET;
            end
            jvc_pkg::JVC_CAP_IR: begin
                next_ir_sh = `JVC_IR_CAPTURE;
            end
            jvc_pkg::JVC_SHIFT_IR: begin
                next_ir_sh = {tdi, ir_sh[`JVC_IR_LEN-1:1]};
            end
            jvc_pkg::JVC_UPD_IR: begin
                next_ir = ir_sh;
            end
            // capture loads the last scan update value back for reading; command and bypass stages clear
            jvc_pkg::JVC_CAP_DR: begin
                next_byp = 1'b0;
                next_scan_sh = scan;
                next_cmd_sh = `JVC_CMD_RESET;
            end
            // shift only moves the selected chain, nothing acts yet
            jvc_pkg::JVC_SHIFT_DR: begin
                case (dr_sel(ir))
                    2'h1: next_scan_sh = {tdi, scan_sh[`JVC_SCAN_LEN-1:1]};
                    2'h2: next_cmd_sh = {tdi, cmd_sh[`JVC_CMD_LEN-1:1]};
                    default: next_byp = tdi;
                endcase
            end
            // commands are decoded at update only
            jvc_pkg::JVC_UPD_DR: begin
                if (dr_sel(ir) == 2'h1) begin
                    next_scan = scan_sh;
                end else if (dr_sel(ir) == 2'h2) begin
                    // reserved codes fall through with no effect
                    if (cmd_sh == `JVC_CMD_MASTER_CLEAR) begin
                        next_master_clear_reset_tgl = ~master_clear_reset_tgl;
                    end else if (cmd_sh == `JVC_CMD_PIN_REMAP) begin
                        next_remap = 1'b1;
                    end
                end
            end
            default: begin
            end
        endcase
    end

    // output stage on the falling edge of tck
    always_comb begin
        next_tdo_q = tdo_q;
        next_tdo_en_q = 1'b0;
        if (tap == jvc_pkg::JVC_SHIFT_IR) begin
            next_tdo_q = ir_sh[0];
            next_tdo_en_q = 1'b1;
        end else if (tap == jvc_pkg::JVC_SHIFT_DR) begin
            next_tdo_en_q = 1'b1;
            case (dr_sel(ir))
                2'h1: next_tdo_q = scan_sh[0];
                2'h2: next_tdo_q = cmd_sh[0];
                default: next_tdo_q = byp;
            endcase
        end
    end

    // link domain registers; master clear never reaches them
    always_ff @(posedge tck or negedge nrst) begin
        if (!nrst) begin
            tap <= jvc_pkg::JVC_RESET;
            ir_sh <= `JVC_IR_RESET;
            ir <= `JVC_IR_RESET;
            cmd_sh <= `JVC_CMD_RESET;
            scan_sh <= `JVC_SCAN_RESET;
            scan <= `JVC_SCAN_RESET;
            byp <= 1'b0;
            master_clear_reset_tgl <= 1'b0;
            remap <= 1'b0;
        end else begin
            tap <= next_tap;
            ir_sh <= next_ir_sh;
            ir <= next_ir;
            cmd_sh <= next_cmd_sh;
            scan_sh <= next_scan_sh;
            scan <= next_scan;
            byp <= next_byp;
            master_clear_reset_tgl <= next_master_clear_reset_tgl;
            remap <= next_remap;
        end
    end

    // falling edge registers for tdo
    always_ff @(negedge tck or negedge nrst) begin
        if (!nrst) begin
            tdo_q <= 1'b0;
            tdo_en_q <= 1'b0;
        end else begin
            tdo_q <= next_tdo_q;
            tdo_en_q <= next_tdo_en_q;
        end
    end

    // pin mux: remapped pins pass straight to the programming engine
    always_comb begin
        prog_clock_pin = remap & tck;
        prog_data_pin = remap & tdi;
        tdo = remap ? prog_data_out : tdo_q;
        tdo_oe = remap ? prog_data_out_oe : tdo_en_q;
    end

    // system domain next values: crossings and master clear length
    always_comb begin
        next_master_clear_reset_sync = {master_clear_reset_sync[1:0], master_clear_reset_tgl};
        next_remap_sync = {remap_sync[0], remap};
        next_master_clear_reset_cnt = master_clear_reset_cnt;
        next_master_clear_reset_out = master_clear_reset_out;
        // edge seen between second and third stage starts the reset
        if (master_clear_reset_sync[2] != master_clear_reset_sync[1]) begin
            next_master_clear_reset_cnt = `JVC_MASTER_CLEAR_RESET_CNT_W'(`JVC_MASTER_CLEAR_RESET_CYCLES);
            next_master_clear_reset_out = 1'b1;
        end else if (master_clear_reset_cnt != '0) begin
            next_master_clear_reset_cnt = master_clear_reset_cnt - 1'b1;
            next_master_clear_reset_out = (master_clear_reset_cnt != `JVC_MASTER_CLEAR_RESET_CNT_W'(1));
        end else begin
            next_master_clear_reset_out = 1'b0;
        end
    end

    // system domain registers, frozen while en is low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            master_clear_reset_sync <= 3'h0;
            remap_sync <= 2'h0;
            master_clear_reset_cnt <= '0;
            master_clear_reset_out <= 1'b0;
        end else if (en) begin
            master_clear_reset_sync <= next_master_clear_reset_sync;
            remap_sync <= next_remap_sync;
            master_clear_reset_cnt <= next_master_clear_reset_cnt;
            master_clear_reset_out <= next_master_clear_reset_out;
        end
    end

    // device side outputs
    assign master_clear_reset = master_clear_reset_out;
    assign prog_remap_active = remap_sync[1];
    assign enhanced_prog_allowed = ~remap_sync[1];
    assign vendor_scan_value = scan;
endmodule : jvc_top

`default_nettype wire

// File: tb/jvc_top_asserts.sv
// port checker for the vendor command extension
`timescale 1ns/1ps
`include "jvc_defs.svh"
`default_nettype none
module jvc_top_asserts (
    // system clock domain
    input wire logic clk,
    input wire logic nrst,
    input wire logic en,
    // link pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    // programming side
    input wire logic prog_clock_pin,
    input wire logic prog_data_pin,
    input wire logic prog_data_out,
    input wire logic prog_data_out_oe,
    // device side
    input wire logic master_clear_reset,
    input wire logic prog_remap_active,
    input wire logic enhanced_prog_allowed,
    input wire logic [`JVC_SCAN_LEN-1:0] vendor_scan_value
);
    // everything is judged on the system clock
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // pulse holds exactly sixteen cycles
    a_master_clear_reset_width: assert property (
        $rose(master_clear_reset) |-> master_clear_reset[*8] ##1
        master_clear_reset[*8] ##1 !master_clear_reset)
        else $error("master clear pulse width wrong");
    // a falling pulse was high sixteen cycles back
    a_master_clear_reset_drop: assert property (
        $fell(master_clear_reset) |-> $past(master_clear_reset, 16))
        else $error("master clear fell too early");
    // clearing the device leaves the scan register alone
    a_master_clear_reset_keeps_scan: assert property (
        $rose(master_clear_reset) |=> $stable(vendor_scan_value))
        else $error("scan register disturbed by master clear");
    // remapped clock follows the link clock
    a_remap_clock_pin: assert property (
        prog_remap_active |-> prog_clock_pin == tck)
        else $error("programming clock not following link clock");
    // remapped data input follows the serial input
    a_remap_data_pin: assert property (
        prog_remap_active |-> prog_data_pin == tdi)
        else $error("programming data not following serial input");
    // remap holds until reset
    a_remap_sticky: assert property (
        prog_remap_active |=> prog_remap_active)
        else $error("remap dropped without reset");
    // serial output carries the engine's data while remapped
    a_remap_tdo_route: assert property (
        prog_remap_active |-> tdo == prog_data_out &&
        tdo_oe == prog_data_out_oe)
        else $error("serial output not routed from engine");
    // enhanced method blocked exactly while remapped
    a_enh_prog_block: assert property (
        enhanced_prog_allowed != prog_remap_active)
        else $error("enhanced programming gate wrong");
endmodule : jvc_top_asserts
bind jvc_top jvc_top_asserts jvc_top_asserts_inst (
    .clk(clk), .nrst(nrst), .en(en), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .prog_clock_pin(prog_clock_pin),
    .prog_data_pin(prog_data_pin), .prog_data_out(prog_data_out),
    .prog_data_out_oe(prog_data_out_oe),
    .master_clear_reset(master_clear_reset),
    .prog_remap_active(prog_remap_active),
    .enhanced_prog_allowed(enhanced_prog_allowed),
    .vendor_scan_value(vendor_scan_value)
);
`default_nettype wire

// File: tb/jvc_ctl.sv
// model of the external test controller driving the link
`timescale 1ns/1ps
`default_nettype none
module jvc_ctl (
    // link pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // link clock stands low between frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one 6 ns link cycle, output sampled at the rising edge
    task automatic tick(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #3;
        q = tdo;
        tck = 1'b1;
        #3;
        tck = 1'b0;
    endtask : tick
    // leave update and settle in idle
    task automatic upd();
        logic q;
        tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
    endtask : upd
    // load an instruction, lsb first, and update it
    task automatic ir(input logic [3:0] code);
        logic q;
        tick(1'b0, 1'b0, q);
        tick(1'b1, 1'b0, q);
        tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        tick(1'b0, 1'b0, q);
        for (int i = 0; i < 4; i++) begin
            tick(i == 3, code[i], q);
        end
        upd();
    endtask : ir
    // shift n data bits, lsb first, stopping in exit1
    task automatic dr(input int n, input logic [15:0] din,
                      output logic [15:0] dout);
        logic q;
        dout = 16'h0000;
        tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        tick(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
    endtask : dr
endmodule : jvc_ctl
`default_nettype wire

// File: tb/test_jvc_top.sv
// self-checking bench for the vendor command extension
`timescale 1ns/1ps
`include "jvc_defs.svh"
`default_nettype none
module test_jvc_top;
    // instruction, length, data in, data out, scan value after
    typedef struct {
        logic [3:0] ir;
        int n;
        logic [15:0] din;
        logic [15:0] dout;
        logic [15:0] sv;
    } jvc_row_t;
    jvc_row_t rows [6] = '{
        '{4'h7, 16, 16'ha5c3, 16'h0000, 16'ha5c3},
        '{4'h7, 16, 16'h1234, 16'ha5c3, 16'h1234},
        '{4'hf, 8, 16'h00b7, 16'h006e, 16'h1234},
        '{4'h3, 8, 16'h0081, 16'h0002, 16'h1234},
        '{4'h8, 16, 16'hc355, 16'h5500, 16'h1234},
        '{4'h8, 8, 16'h00ff, 16'h0000, 16'h1234}
    };
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic pdo = 1'b0;
    logic pdo_oe = 1'b0;
    logic en = 1'b1; // system clock enable
    logic tck, tms, tdi, tdo, tdo_oe, pck, pdi, mcr, rem, enh;
    logic [15:0] sv;
    int fail_count = 0;
    int total_checks = 0;
    // system clock, 8 ns
    always #4 clk = ~clk;
    jvc_top jvc_top_inst (
        .clk(clk), .nrst(nrst), .en(en), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .prog_clock_pin(pck),
        .prog_data_pin(pdi), .prog_data_out(pdo),
        .prog_data_out_oe(pdo_oe), .master_clear_reset(mcr),
        .prog_remap_active(rem), .enhanced_prog_allowed(enh),
        .vendor_scan_value(sv)
    );
    jvc_ctl jvc_ctl_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    // compare and count
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, want, seen);
        end
    endtask : check
    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    // cut a hang short
    initial begin
        #100000;
        fail_count++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        logic [15:0] got;
        int hi;
        repeat (4) @(posedge clk);
        #1 nrst = 1'b1;
        check("rst", {12'h000, tdo_oe, mcr, rem, enh}, 16'h0001);
        foreach (rows[i]) begin
            jvc_ctl_inst.ir(rows[i].ir);
            jvc_ctl_inst.dr(rows[i].n, rows[i].din, got);
            jvc_ctl_inst.upd();
            repeat (8) @(posedge clk);
            check("dr_out", got, rows[i].dout);
            check("scan", sv, rows[i].sv);
            check("clear", 16'(mcr), 16'h0000);
        end
        // master clear acts only once the command is updated
        jvc_ctl_inst.ir(`JVC_INS_CMD_SELECT);
        jvc_ctl_inst.dr(8, 16'(`JVC_CMD_MASTER_CLEAR), got);
        repeat (10) @(posedge clk);
        check("early", 16'(mcr), 16'h0000);
        jvc_ctl_inst.upd();
        hi = 0;
        // sample a step after each edge, once the output has settled
        repeat (40) begin
            @(posedge clk);
            #1 hi += int'(mcr);
        end
        check("width", 16'(hi), 16'h0010);
        jvc_ctl_inst.ir(`JVC_INS_VENDOR_SCAN);
        jvc_ctl_inst.dr(16, 16'h0f0f, got);
        jvc_ctl_inst.upd();
        check("scan_kept", got, 16'h1234);
        // load the command select, then the remap command
        jvc_ctl_inst.ir(`JVC_INS_CMD_SELECT);
        jvc_ctl_inst.dr(8, 16'(`JVC_CMD_PIN_REMAP), got);
        jvc_ctl_inst.upd();
        repeat (6) @(posedge clk);
        #1;
        check("remap", {14'h0000, rem, enh}, 16'h0002);
        for (int k = 0; k < 4; k++) begin
            jvc_ctl_inst.tdi = k[0];
            jvc_ctl_inst.tck = k[1];
            pdo = ~k[0];
            pdo_oe = k[1];
            #1;
            check("pins", {12'h000, pck, pdi, tdo, tdo_oe},
                  {12'h000, k[1], k[0], ~k[0], k[1]});
        end
        // a second reset is the only way out of remap
        jvc_ctl_inst.tck = 1'b0;
        @(posedge clk);
        #1 nrst = 1'b0;
        repeat (4) @(posedge clk);
        #1 nrst = 1'b1;
        check("rst2", {12'h000, tdo_oe, mcr, rem, enh}, 16'h0001);
        check("pins_rst", {14'h0000, pck, pdi}, 16'h0000);
        check("scan_rst", sv, `JVC_SCAN_RESET);
        // a low enable holds the master clear back until it rises
        en = 1'b0;
        jvc_ctl_inst.ir(`JVC_INS_CMD_SELECT);
        jvc_ctl_inst.dr(8, 16'(`JVC_CMD_MASTER_CLEAR), got);
        jvc_ctl_inst.upd();
        repeat (20) @(posedge clk);
        #1;
        check("frozen", 16'(mcr), 16'h0000);
        en = 1'b1;
        hi = 0;
        repeat (40) begin
            @(posedge clk);
            #1 hi += int'(mcr);
        end
        check("width_en", 16'(hi), 16'h0010);
        tally_and_finish();
    end
endmodule : test_jvc_top
`default_nettype wire
